// [logic/light_sense_pkg.sv]
// constants, field layouts and carriers for the light measurement control
// assumes one 40 MHz clock and a register port driven by a serial slave
package light_sense_pkg;

  // register offsets
  localparam logic [7:0] CMD1_ADDR    = 8'h00;
  localparam logic [7:0] CMD2_ADDR    = 8'h01;
  localparam logic [7:0] DATA_LO_ADDR = 8'h02;
  localparam logic [7:0] DATA_HI_ADDR = 8'h03;

  // field positions
  localparam int OP_MSB    = 7;
  localparam int OP_LSB    = 5;
  localparam int RES_MSB   = 3;
  localparam int RES_LSB   = 2;
  localparam int RANGE_MSB = 1;
  localparam int RANGE_LSB = 0;

  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] CMD1_MASK = 8'hE0;
  localparam logic [7:0] CMD2_MASK = 8'h0F;

  // reset values
  localparam logic [7:0]  CMD1_RESET   = 8'h00;
  localparam logic [7:0]  CMD2_RESET   = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // operation codes
  localparam logic [2:0] OP_POWER_DOWN = 3'h0;
  localparam logic [2:0] OP_VIS_ONCE   = 3'h1;
  localparam logic [2:0] OP_IR_ONCE    = 3'h2;
  localparam logic [2:0] OP_VIS_CONT   = 3'h5;
  localparam logic [2:0] OP_IR_CONT    = 3'h6;

  // resolution codes
  localparam logic [1:0] RES_16 = 2'h0;
  localparam logic [1:0] RES_12 = 2'h1;
  localparam logic [1:0] RES_8  = 2'h2;
  localparam logic [1:0] RES_4  = 2'h3;

  // timing: full-resolution integration time and its cycle count
  localparam int MCLK_KHZ        = 40000;
  localparam int INT_TIME_MS     = 105;
  localparam int INT_CYCLES_FULL = MCLK_KHZ * INT_TIME_MS;
  localparam int FULL_SPAN       = 65536;

  // register port request from the serial slave engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } regReq_t;

  // controls toward the analog front end
  typedef struct packed {
    logic       powerOn;
    logic       infrared;
    logic [1:0] range;
  } afeCtrl_t;

  function automatic logic opActive(input logic [2:0] op);
    return (op == OP_VIS_ONCE) || (op == OP_IR_ONCE) ||
           (op == OP_VIS_CONT) || (op == OP_IR_CONT);
  endfunction

  function automatic logic opOnce(input logic [2:0] op);
    return (op == OP_VIS_ONCE) || (op == OP_IR_ONCE);
  endfunction

  function automatic logic opInfrared(input logic [2:0] op);
    return (op == OP_IR_ONCE) || (op == OP_IR_CONT);
  endfunction

  // last tick index, equal to the largest count at that resolution
  function automatic logic [15:0] spanLastOf(input logic [1:0] res);
    case (res)
      RES_16:  return 16'hFFFF;
      RES_12:  return 16'h0FFF;
      RES_8:   return 16'h00FF;
      default: return 16'h000F;
    endcase
  endfunction

endpackage

// [logic/charge_balance_counter.sv]
// counts balance pulses of one charge-balancing channel
// assumes balancePulse is asynchronous to mclk and slower than mclk / 2
`timescale 1ns/1ps
module charge_balance_counter
  import light_sense_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clear,
  input  wire logic        integrate,
  input  wire logic        balancePulse,
  input  wire logic [15:0] maxCount,
  output logic      [15:0] count
);

  logic        syncA;
  logic        syncB;
  logic        pulsePrev;
  logic [15:0] next_count;

  // saturating count of rising balance edges, capped at resolution
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = RESULT_RESET;
    end else if (integrate && syncB && !pulsePrev && count < maxCount) begin
      next_count = count + 16'h0001;
    end
  end

  // two-stage synchroniser; only syncB feeds the edge detector
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      syncA     <= 1'b0;
      syncB     <= 1'b0;
      pulsePrev <= 1'b0;
      count     <= RESULT_RESET;
    end else begin
      syncA     <= balancePulse;
      syncB     <= syncA;
      pulsePrev <= syncB;
      count     <= next_count;
    end
  end

endmodule

// [logic/light_sense_ctrl.sv]
// measurement sequencing and register file of the light sensor
// assumes a serial slave engine on the register port, on mclk
// What this block does
// - after reset the unit sits powered down, nothing converting
// - result registers read zero until a conversion completes
// - a one-shot command leaves power-down and starts one conversion
// - one-shot powers down after finishing and keeps the result; a CMD2 write in its last cycle leaves it converting visible back to back
// - continuous mode converts back to back, refreshing the result
// - power-down command stops conversion and powers down
// - four modes: visible or infrared, once or continuous
// - modes may be written in any order; each new one is obeyed
// - result is an unsigned count no wider than the resolution
// - counter width 4, 8, 12 or 16 sets integration length
// - conversion integrates balance pulses into up to 16 bits
// - full resolution integrates about 105 ms
// - range is host-settable; range 0 is the most sensitive
// - host reads the raw count through the result registers
`timescale 1ns/1ps
module light_sense_ctrl
  import light_sense_pkg::*;
#(
  parameter int INT_CYCLES = INT_CYCLES_FULL
)(
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire regReq_t    regReq,
  output logic      [7:0] regRdData,
  input  wire logic       visibleSensePulse,
  input  wire logic       infraredSensePulse,
  output afeCtrl_t        afeCtrl,
  output logic            conversionDone
);

  // oscillator tick period; 105 ms over 65536 ticks rounds down
  localparam int OSC_DIV = (INT_CYCLES / FULL_SPAN < 1) ? 1 :
                           INT_CYCLES / FULL_SPAN;
  localparam logic [15:0] OSC_LAST = 16'(OSC_DIV - 1);

  typedef enum logic {sPowerDown, sConvert} state_t;

  state_t      state;
  state_t      next_state;
  logic [7:0]  cmd1;
  logic [7:0]  next_cmd1;
  logic [7:0]  cmd2;
  logic [7:0]  next_cmd2;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [15:0] prescale;
  logic [15:0] next_prescale;
  logic [15:0] tickCnt;
  logic [15:0] next_tickCnt;
  logic [7:0]  next_regRdData;
  afeCtrl_t    next_afeCtrl;
  logic        next_conversionDone;
  logic        everDone;

  logic [2:0]  op;
  logic [1:0]  res;
  logic [15:0] spanLast;
  logic        wr1;
  logic        wr2;
  logic        cfgWrite;
  logic [2:0]  newOp;
  logic        tick;
  logic        done;
  logic        clearCnt;
  logic [15:0] visCount;
  logic [15:0] irCount;
  logic [15:0] activeCount;

  // decoded register fields and write strobes
  assign op       = cmd1[OP_MSB:OP_LSB];
  assign res      = cmd2[RES_MSB:RES_LSB];
  assign spanLast = spanLastOf(res);
  assign wr1      = regReq.wr && (regReq.addr == CMD1_ADDR);
  assign wr2      = regReq.wr && (regReq.addr == CMD2_ADDR);
  assign cfgWrite = wr1 || wr2;
  assign newOp    = wr1 ? regReq.wdata[OP_MSB:OP_LSB] : op;

  // oscillator tick and end of integration
  assign tick = (state == sConvert) && (prescale == OSC_LAST);
  assign done = tick && (tickCnt == spanLast);

  // channel pick follows the stored mode
  assign activeCount = opInfrared(op) ? irCount : visCount;

  // one counter per photodiode channel; both share the clear, but only the selected channel integrates
  charge_balance_counter visChannel (
    .mclk         (mclk),
    .nrst         (nrst),
    .clear        (clearCnt),
    .integrate    ((state == sConvert) && !opInfrared(op)),
    .balancePulse (visibleSensePulse),
    .maxCount     (spanLast),
    .count        (visCount)
  );

  charge_balance_counter irChannel (
    .mclk         (mclk),
    .nrst         (nrst),
    .clear        (clearCnt),
    .integrate    ((state == sConvert) && opInfrared(op)),
    .balancePulse (infraredSensePulse),
    .maxCount     (spanLast),
    .count        (irCount)
  );

  // sequencer, settings and result: next values
  always_comb begin
    next_state          = state;
    next_cmd1           = cmd1;
    next_cmd2           = cmd2;
    next_result         = result;
    next_prescale       = prescale;
    next_tickCnt        = tickCnt;
    next_conversionDone = 1'b0;
    clearCnt            = 1'b0;
    case (state)
      sPowerDown: begin
        next_prescale = 16'h0000;
        next_tickCnt  = 16'h0000;
      end
      sConvert: begin
        next_prescale = tick ? 16'h0000 : prescale + 16'h0001;
        if (tick) begin
          next_tickCnt = tickCnt + 16'h0001;
        end
        if (done) begin
          // one store keeps both bytes from the same conversion
          next_result         = activeCount;
          next_conversionDone = 1'b1;
          next_tickCnt        = 16'h0000;
          clearCnt            = 1'b1;
          if (opOnce(op)) begin
            next_state = sPowerDown;
            next_cmd1  = {OP_POWER_DOWN, cmd1[OP_LSB-1:0]};
          end else begin
            next_state = sConvert;
          end
        end
      end
      default: begin
        next_state = sPowerDown;
      end
    endcase
    // a settings write overrides the sequencer and restarts cleanly
    if (wr1) begin
      next_cmd1 = regReq.wdata & CMD1_MASK;
    end
    if (wr2) begin
      next_cmd2 = regReq.wdata & CMD2_MASK;
    end
    if (cfgWrite) begin
      next_prescale = 16'h0000;
      next_tickCnt  = 16'h0000;
      clearCnt      = 1'b1;
      if (opActive(newOp)) begin
        next_state = sConvert;
      end else begin
        next_state = sPowerDown;
      end
    end
  end

  // read data and front-end controls; unmapped offsets read zero
  always_comb begin
    next_regRdData = regRdData;
    if (regReq.rd) begin
      case (regReq.addr)
        CMD1_ADDR:    next_regRdData = cmd1;
        CMD2_ADDR:    next_regRdData = cmd2;
        DATA_LO_ADDR: next_regRdData = result[7:0];
        DATA_HI_ADDR: next_regRdData = result[15:8];
        default:      next_regRdData = 8'h00;
      endcase
    end
    next_afeCtrl.powerOn  = (next_state == sConvert);
    next_afeCtrl.infrared = opInfrared(next_cmd1[OP_MSB:OP_LSB]);
    next_afeCtrl.range    = next_cmd2[RANGE_MSB:RANGE_LSB];
  end

  // registers; reset leaves the unit powered down with a zero result
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state          <= sPowerDown;
      cmd1           <= CMD1_RESET;
      cmd2           <= CMD2_RESET;
      result         <= RESULT_RESET;
      prescale       <= 16'h0000;
      tickCnt        <= 16'h0000;
      regRdData      <= 8'h00;
      afeCtrl        <= '0;
      conversionDone <= 1'b0;
    end else begin
      state          <= next_state;
      cmd1           <= next_cmd1;
      cmd2           <= next_cmd2;
      result         <= next_result;
      prescale       <= next_prescale;
      tickCnt        <= next_tickCnt;
      regRdData      <= next_regRdData;
      afeCtrl        <= next_afeCtrl;
      conversionDone <= next_conversionDone;
    end
  end

  // helper for checks: has any conversion finished since reset
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      everDone <= 1'b0;
    end else if (done) begin
      everDone <= 1'b1;
    end
  end

  // checks
  a_reset_power_down:
    assert property (@(posedge mclk) disable iff (!nrst)
      $past(!nrst) |-> (state == sPowerDown && !afeCtrl.powerOn))
    else $error("unit not powered down after reset");

  a_result_zero_early:
    assert property (@(posedge mclk) disable iff (!nrst)
      (result != 16'h0000) |-> everDone)
    else $error("result nonzero before any conversion");

  a_once_start:
    assert property (@(posedge mclk) disable iff (!nrst)
      (wr1 && opOnce(regReq.wdata[OP_MSB:OP_LSB]))
      |=> (state == sConvert && tickCnt == 16'h0000 && afeCtrl.powerOn))
    else $error("one-shot command did not start a conversion");

  a_once_power_down:
    assert property (@(posedge mclk) disable iff (!nrst)
      (done && opOnce(op) && !cfgWrite)
      |=> (state == sPowerDown && result == $past(activeCount))
          ##1 (result == $past(result)))
    else $error("one-shot did not stop or lost its result");

  a_cont_refresh:
    assert property (@(posedge mclk) disable iff (!nrst)
      (done && !opOnce(op) && !cfgWrite)
      |=> (state == sConvert && result == $past(activeCount)
           && tickCnt == 16'h0000))
    else $error("continuous mode did not refresh and rerun");

  a_power_down_cmd:
    assert property (@(posedge mclk) disable iff (!nrst)
      (wr1 && !opActive(regReq.wdata[OP_MSB:OP_LSB]))
      |=> (state == sPowerDown && !afeCtrl.powerOn))
    else $error("power-down command ignored");

  a_result_width:
    assert property (@(posedge mclk) disable iff (!nrst)
      done |=> (result <= $past(spanLast)))
    else $error("result wider than resolution");

  a_span_length:
    assert property (@(posedge mclk) disable iff (!nrst)
      (state == sConvert && !tick && !cfgWrite)
      |=> (tickCnt == $past(tickCnt)))
    else $error("tick count moved without an oscillator tick");

  a_tick_rate:
    assert property (@(posedge mclk) disable iff (!nrst)
      tick |-> (prescale == OSC_LAST && $past(prescale) == OSC_LAST - 16'h1
                || OSC_LAST == 16'h0000))
    else $error("oscillator tick period wrong");

  a_restart_write:
    assert property (@(posedge mclk) disable iff (!nrst)
      (cfgWrite && state == sConvert && opActive(newOp))
      |=> (state == sConvert && tickCnt == 16'h0000
           && prescale == 16'h0000 && activeCount == 16'h0000))
    else $error("settings write did not restart conversion");

  a_channel_select:
    assert property (@(posedge mclk) disable iff (!nrst)
      (state == sConvert)
      |-> (afeCtrl.powerOn && afeCtrl.infrared == opInfrared(op)))
    else $error("front end not on the selected channel");

  a_range_follow:
    assert property (@(posedge mclk) disable iff (!nrst)
      afeCtrl.range == cmd2[RANGE_MSB:RANGE_LSB])
    else $error("range control differs from register");

  a_read_low:
    assert property (@(posedge mclk) disable iff (!nrst)
      (regReq.rd && regReq.addr == DATA_LO_ADDR)
      |=> (regRdData == $past(result[7:0])))
    else $error("low result byte read wrong");

  a_read_high:
    assert property (@(posedge mclk) disable iff (!nrst)
      (regReq.rd && regReq.addr == DATA_HI_ADDR)
      |=> (regRdData == $past(result[15:8])))
    else $error("high result byte read wrong");

  a_result_update:
    assert property (@(posedge mclk) disable iff (!nrst)
      (result != $past(result)) |-> conversionDone)
    else $error("result changed outside a conversion end");

endmodule

// [sim/light_host_model.sv]
// host-side register master standing in for the serial slave engine
// assumes the bench calls its tasks one at a time, on mclk
`timescale 1ns/1ps
module light_host_model
  import light_sense_pkg::*;
(
  input  wire logic mclk,
  output regReq_t   regReq
);
  initial regReq = '0;

  // one-cycle write strobe; address and data scrambled once released
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 regReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    #1 regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // one-cycle read strobe; the bench watches the answer
  task automatic read_reg(input logic [7:0] a);
    @(posedge mclk);
    #1 regReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'hA5};
    @(posedge mclk);
    #1 regReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'h5A};
  endtask
endmodule

// [sim/light_sense_ctrl_bench.sv]
// self-checking bench for the light measurement control
// assumes INT_CYCLES of 65536, so one oscillator tick per mclk cycle
`timescale 1ns/1ps
module light_sense_ctrl_bench;
  import light_sense_pkg::*;
  logic       mclk;
  logic       nrst;
  regReq_t    regReq;
  logic [7:0] regRdData;
  logic       visPulse;
  logic       irPulse;
  afeCtrl_t   afeCtrl;
  logic       conversionDone;
  logic       rdSeen;
  logic [7:0] expRd[$];
  logic [1:0] rng;
  logic [2:0] ops[4];
  int         cyc;
  int         num_errors;
  int         samples_checked;

  light_sense_ctrl #(.INT_CYCLES(65536)) light_sense_ctrl_inst (
    .mclk              (mclk),
    .nrst              (nrst),
    .regReq            (regReq),
    .regRdData         (regRdData),
    .visibleSensePulse (visPulse),
    .infraredSensePulse(irPulse),
    .afeCtrl           (afeCtrl),
    .conversionDone    (conversionDone)
  );

  light_host_model light_host_model_inst (
    .mclk  (mclk),
    .regReq(regReq)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // read answers land the cycle after the strobe; oldest note first
  always @(posedge mclk) rdSeen <= regReq.rd;
  always @(negedge mclk) begin
    if (rdSeen === 1'b1 && expRd.size() > 0)
      check("read data", {8'h00, expRd.pop_front()}, {8'h00, regRdData});
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expRd.push_back(e);
    light_host_model_inst.read_reg(a);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    light_host_model_inst.write_reg(a, d);
  endtask

  // balance pulses, two cycles high and two low, slower than mclk / 2
  task automatic pulses(input int nv, input int ni);
    fork
      repeat (nv) begin
        @(posedge mclk);
        #1 visPulse = 1'b1;
        repeat (2) @(posedge mclk);
        #1 visPulse = 1'b0;
        @(posedge mclk);
      end
      repeat (ni) begin
        @(posedge mclk);
        #1 irPulse = 1'b1;
        repeat (2) @(posedge mclk);
        #1 irPulse = 1'b0;
        @(posedge mclk);
      end
    join
  endtask

  // bounded wait for the end of a conversion, counting cycles
  task automatic wait_done(input int maxc);
    cyc = 0;
    while (cyc < maxc) begin
      @(posedge mclk);
      cyc++;
      #1;
      if (conversionDone === 1'b1) return;
    end
    num_errors++;
    complete_run();
  endtask

  task automatic start(input logic [2:0] op, input logic [1:0] res);
    wr(CMD2_ADDR, {4'h0, res, rng});
    wr(CMD1_ADDR, {op, 5'h00});
    check("power on", 16'h0001, {15'h0, afeCtrl.powerOn});
    check("channel", {15'h0, op == OP_IR_ONCE || op == OP_IR_CONT},
          {15'h0, afeCtrl.infrared});
    check("range", {14'h0, rng}, {14'h0, afeCtrl.range});
  endtask

  // len of zero skips the length check for a conversion already running
  task automatic convert(input int nv, input int ni, input bit ir,
                         input int len);
    logic [15:0] e;
    e = ir ? ni[15:0] : nv[15:0];
    fork
      pulses(nv, ni);
    join_none
    wait_done(5000);
    if (len > 0) check("conv length", len[15:0], cyc[15:0]);
    rd(DATA_LO_ADDR, e[7:0]);
    rd(DATA_HI_ADDR, e[15:8]);
  endtask

  initial begin
    nrst = 1'b0;
    visPulse = 1'b0;
    irPulse = 1'b0;
    rng = 2'h0;
    num_errors = 0;
    samples_checked = 0;
    ops = '{OP_VIS_ONCE, OP_IR_ONCE, OP_VIS_CONT, OP_IR_CONT};
    void'($urandom(52));
    repeat (5) @(posedge mclk);
    #1 nrst = 1'b1;
    check("power at reset", 16'h0000, {15'h0, afeCtrl.powerOn});
    for (int a = 0; a < 5; a++) rd(a[7:0], 8'h00);
    // settings alone start nothing; reserved bits read zero
    wr(CMD2_ADDR, 8'hFF);
    rd(CMD2_ADDR, 8'h0F);
    check("idle power", 16'h0000, {15'h0, afeCtrl.powerOn});
    wr(CMD1_ADDR, 8'h1F);
    rd(CMD1_ADDR, 8'h00);
    // every mode in turn, the unselected channel pulsing too
    for (int i = 0; i < 4; i++) begin
      rng = 2'($urandom_range(3));
      start(ops[i], RES_8);
      convert($urandom_range(50), $urandom_range(50), i % 2, 256);
      repeat (2) @(posedge mclk);
      #1;
      if (i < 2) begin
        check("auto off", 16'h0000, {15'h0, afeCtrl.powerOn});
        rd(CMD1_ADDR, 8'h00);
      end else begin
        check("still on", 16'h0001, {15'h0, afeCtrl.powerOn});
        rd(CMD1_ADDR, {ops[i], 5'h00});
        convert($urandom_range(50), $urandom_range(50), i % 2, 0);
        wr(CMD1_ADDR, {OP_POWER_DOWN, 5'h00});
        check("stop", 16'h0000, {15'h0, afeCtrl.powerOn});
      end
    end
    // settings rewrite in mid-conversion discards the partial count
    start(OP_VIS_CONT, RES_8);
    pulses(20, 0);
    wr(CMD2_ADDR, {4'h0, RES_8, rng});
    convert(7, 0, 1'b0, 256);
    wr(CMD1_ADDR, {OP_POWER_DOWN, 5'h00});
    // shortest and longer resolutions; 300 counts use the high byte
    start(OP_VIS_ONCE, RES_4);
    convert(2, 0, 1'b0, 16);
    start(OP_VIS_ONCE, RES_12);
    convert(300, 0, 1'b0, 4096);
    rd(DATA_HI_ADDR, 8'h01);
    // reset in mid-conversion clears the result and powers down
    start(OP_IR_CONT, RES_16);
    pulses(3, 3);
    #1 nrst = 1'b0;
    repeat (3) @(posedge mclk);
    #1 nrst = 1'b1;
    check("reset power", 16'h0000, {15'h0, afeCtrl.powerOn});
    check("reset channel", 16'h0000, {15'h0, afeCtrl.infrared});
    rd(DATA_LO_ADDR, 8'h00);
    rd(DATA_HI_ADDR, 8'h00);
    rd(CMD1_ADDR, 8'h00);
    repeat (4) @(posedge mclk);
    complete_run();
  end
endmodule
